// File: lbc_map.svh
// Named constants for the local bus host controller.
`ifndef LBC_MAP_SVH
`define LBC_MAP_SVH

`define LBC_CLK_NS 20
`define LBC_DECODE_NS 20
`define LBC_DECODE_CYC ((`LBC_DECODE_NS + `LBC_CLK_NS - 1) / `LBC_CLK_NS)
`define LBC_SYNC_STAGES 2
`define LBC_DECODE_WAIT (`LBC_DECODE_CYC + `LBC_SYNC_STAGES)
`define LBC_PIN_W 4
`define LBC_DATA_W 32
`define LBC_CNT_W 4
`define LBC_BE_IDLE 4'hF
`define LBC_BE_MASK_HI 4'hC
`define LBC_BE_MASK_LO 4'h3
`define LBC_PIN_CLAIM 0
`define LBC_PIN_LOCAL_READY 1
`define LBC_PIN_BURST_READY 2
`define LBC_PIN_SIZE16 3

`endif

// File: lbc_pkg.sv
// Types shared by the local bus host controller files.
`default_nettype none
package lbc_pkg;
   typedef enum logic [2:0] {
      ST_IDLE,
      ST_DECODE,
      ST_CPU_WAIT,
      ST_IO_T1,
      ST_IO_T2,
      ST_IO_END
   } lbc_state_t;
endpackage
`default_nettype wire

// File: lbc_sync_if.sv
// Carrier between the controller core and its pin synchroniser.
`timescale 1ns/10ps
`default_nettype none
`include "lbc_map.svh"
interface lbc_sync_if;
   logic [`LBC_PIN_W-1:0] raw_pins;
   logic [`LBC_DATA_W-1:0] raw_data;
   logic [`LBC_PIN_W-1:0] sync_pins;
   logic [`LBC_DATA_W-1:0] sync_data;
   modport src (output raw_pins, output raw_data, input sync_pins, input sync_data);
   modport dst (input raw_pins, input raw_data, output sync_pins, output sync_data);
endinterface
`default_nettype wire

// File: lbc_sync.sv
// Two-stage synchroniser for the active-low target pins and the read data.
`timescale 1ns/10ps
`default_nettype none
`include "lbc_map.svh"
module lbc_sync (
   input wire logic clock,
   input wire logic rst,
   lbc_sync_if.dst pins
);
   logic [`LBC_PIN_W-1:0] pins_meta_q;
   logic [`LBC_DATA_W-1:0] data_meta_q;

   // Pins idle high, so reset loads the inactive level.
   always_ff @(posedge clock) begin
      if (rst) begin
         pins_meta_q <= `LBC_BE_IDLE;
         pins.sync_pins <= `LBC_BE_IDLE;
      end else begin
         pins_meta_q <= pins.raw_pins;
         pins.sync_pins <= pins_meta_q;
      end
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         data_meta_q <= '0;
         pins.sync_data <= '0;
      end else begin
         data_meta_q <= pins.raw_data;
         pins.sync_data <= data_meta_q;
      end
   end
endmodule // lbc_sync
`default_nettype wire

// File: lbc_host_ctrl.sv
// Local bus host controller: processor decode, I/O bus cycle translation, 16-bit split.
//
// Overview of operation
// - Processor cycles: wait the decode interval, then sample the device claim.
// - Claimed cycle: release board ready drivers, and data on reads, promptly.
// - Claim may be ignored on board cache hits or board memory cycles.
// - I/O bus cycles: drive address and derive all local control signals.
// - I/O bus cycles: sample the device claim to find a local target.
// - I/O bus cycles: strobe address when claimed, or always if so chosen.
// - Claimed I/O bus cycles: hold the I/O bus in wait until local ready.
// - Move data between buses, lanes chosen by cycle and byte enables.
// - I/O bus reads: hold read data in a latch after the cycle.
// - Keep burst last low from the first state through the cycle.
// - Support 32 and 16-bit targets; split boundary-crossing cycles on size request.
// - Board splits I/O cycles; processor cycles only return the size request; local masters split their own.
// - Ready return combines target local ready with board ready sources.
`timescale 1ns/10ps
`default_nettype none
`include "lbc_map.svh"
module lbc_host_ctrl
   import lbc_pkg::*;
(
   input wire logic clock,
   input wire logic rst,
   input wire logic cpu_ads_n,
   input wire logic cpu_wr,
   input wire logic cpu_cache_hit,
   input wire logic cpu_local_mem,
   input wire logic board_ready_n,
   input wire logic ads_always,
   input wire logic io_start,
   input wire logic [31:2] io_addr,
   input wire logic [3:0] io_be_n,
   input wire logic io_mio,
   input wire logic io_dc,
   input wire logic io_wr,
   input wire logic [15:0] io_wdata,
   input wire logic local_device_claim_n,
   input wire logic local_ready_n,
   input wire logic burst_ready_n,
   input wire logic size16_request_n,
   input wire logic [31:0] lb_data_i,
   output logic ready_return_n,
   output logic cpu_size16_n,
   output logic board_rdy_oe,
   output logic board_data_oe,
   output logic io_wait,
   output logic io_done,
   output logic io_local,
   output logic [15:0] io_rdata,
   output logic [31:2] lb_addr,
   output logic [3:0] byte_lane_enables_n,
   output logic address_strobe_n,
   output logic lb_mio,
   output logic lb_dc,
   output logic lb_wr,
   output logic burst_last_n,
   output logic lb_ctl_oe,
   output logic [31:0] lb_data_o,
   output logic lb_data_oe
);
   localparam logic [`LBC_CNT_W-1:0] DEC_LAST = `LBC_CNT_W'(`LBC_DECODE_WAIT - 1);
   // I/O bus cycles put their address on the local bus one cycle after the take.
   localparam logic [`LBC_CNT_W-1:0] IO_LAST = `LBC_CNT_W'(`LBC_DECODE_WAIT);

   lbc_state_t state_q;
   logic [`LBC_CNT_W-1:0] cnt_q;
   logic is_io_q, wr_q, bypass_q, claimed_q, split_q, phase_q;
   logic [3:0] be_n_q;
   logic [31:0] rd_q;
   logic claim_s, local_ready_s, size16_s, sample;
   logic [3:0] phase_be_n;
   logic [31:0] rd_merge;

   ////////////////////////////////////////////////////////////////////////////
   // Pin synchronisation.
   lbc_sync_if pin_if ();
   assign pin_if.raw_pins = {size16_request_n, burst_ready_n, local_ready_n,
                             local_device_claim_n};
   assign pin_if.raw_data = lb_data_i;
   lbc_sync u_sync (
      .clock(clock),
      .rst(rst),
      .pins(pin_if.dst)
   );
   assign claim_s = ~pin_if.sync_pins[`LBC_PIN_CLAIM];
   assign local_ready_s = ~pin_if.sync_pins[`LBC_PIN_LOCAL_READY];
   assign size16_s = ~pin_if.sync_pins[`LBC_PIN_SIZE16];

   // The claim is sampled once the decode interval plus synchroniser delay has passed.
   assign sample = (state_q == ST_DECODE)
                   && (cnt_q == (is_io_q ? IO_LAST : DEC_LAST));
   assign phase_be_n = phase_q ? (be_n_q | `LBC_BE_MASK_LO)
                               : (split_q ? (be_n_q | `LBC_BE_MASK_HI) : be_n_q);

   // Only the byte lanes enabled in the current phase replace latched read data.
   always_comb begin
      rd_merge = rd_q;
      for (int i = 0; i < 4; i++) begin
         if (!phase_be_n[i]) begin
            rd_merge[i*8 +: 8] = pin_if.sync_data[i*8 +: 8];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Cycle sequencer.
   always_ff @(posedge clock) begin
      if (rst) begin
         state_q <= ST_IDLE;
         cnt_q <= '0;
      end else begin
         case (state_q)
            ST_IDLE: begin
               cnt_q <= '0;
               if (io_start || !cpu_ads_n) begin
                  state_q <= ST_DECODE;
               end
            end
            ST_DECODE: begin
               cnt_q <= cnt_q + `LBC_CNT_W'(1);
               if (sample) begin
                  if (!is_io_q) begin
                     state_q <= ST_CPU_WAIT;
                  end else if (claim_s || ads_always) begin
                     state_q <= ST_IO_T1;
                  end else begin
                     state_q <= ST_IO_END;
                  end
               end
            end
            ST_CPU_WAIT: begin
               if ((claimed_q && local_ready_s) || (!claimed_q && !board_ready_n)) begin
                  state_q <= ST_IDLE;
               end
            end
            ST_IO_T1: begin
               state_q <= claimed_q ? ST_IO_T2 : ST_IO_END;
            end
            ST_IO_T2: begin
               if (local_ready_s) begin
                  state_q <= (split_q && !phase_q) ? ST_IO_T1 : ST_IO_END;
               end
            end
            default: begin
               state_q <= ST_IDLE;
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Cycle attributes, captured at the start and at the claim sample.
   always_ff @(posedge clock) begin
      if (rst) begin
         is_io_q <= 1'b0;
         wr_q <= 1'b0;
         bypass_q <= 1'b0;
         be_n_q <= `LBC_BE_IDLE;
      end else if (state_q == ST_IDLE) begin
         if (io_start) begin
            is_io_q <= 1'b1;
            wr_q <= io_wr;
            bypass_q <= 1'b0;
            be_n_q <= io_be_n;
         end else if (!cpu_ads_n) begin
            is_io_q <= 1'b0;
            wr_q <= cpu_wr;
            bypass_q <= cpu_cache_hit || cpu_local_mem;
         end
      end
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         claimed_q <= 1'b0;
         split_q <= 1'b0;
         phase_q <= 1'b0;
         cpu_size16_n <= 1'b1;
      end else begin
         cpu_size16_n <= ~size16_s;
         if (sample) begin
            claimed_q <= claim_s && !bypass_q;
            split_q <= is_io_q && size16_s && (be_n_q[1:0] != 2'b11)
                       && (be_n_q[3:2] != 2'b11);
            phase_q <= 1'b0;
         end else if (state_q == ST_IO_T2 && local_ready_s && split_q) begin
            phase_q <= 1'b1;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Board driver release and ready return toward the processor.
   always_ff @(posedge clock) begin
      if (rst) begin
         board_rdy_oe <= 1'b1;
         board_data_oe <= 1'b0;
      end else if (sample) begin
         board_rdy_oe <= !(claim_s && !bypass_q);
         board_data_oe <= !is_io_q && !wr_q && !(claim_s && !bypass_q);
      end else if (state_q == ST_IDLE) begin
         board_rdy_oe <= 1'b1;
         board_data_oe <= 1'b0;
      end
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         ready_return_n <= 1'b1;
      end else begin
         ready_return_n <= !(state_q == ST_CPU_WAIT
                             && ((claimed_q && local_ready_s) || (!claimed_q && !board_ready_n)));
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Local bus control derived from the I/O bus cycle.
   always_ff @(posedge clock) begin
      if (rst) begin
         lb_ctl_oe <= 1'b0;
         lb_addr <= '0;
         lb_mio <= 1'b0;
         lb_dc <= 1'b0;
         lb_wr <= 1'b0;
         byte_lane_enables_n <= `LBC_BE_IDLE;
         burst_last_n <= 1'b1;
         address_strobe_n <= 1'b1;
      end else begin
         address_strobe_n <= !((sample && is_io_q && (claim_s || ads_always))
                               || (state_q == ST_IO_T2 && local_ready_s && split_q && !phase_q));
         if (state_q == ST_IDLE && io_start) begin
            lb_ctl_oe <= 1'b1;
            lb_addr <= io_addr;
            lb_mio <= io_mio;
            lb_dc <= io_dc;
            lb_wr <= io_wr;
            byte_lane_enables_n <= io_be_n;
            burst_last_n <= 1'b0;
         end else if (sample && is_io_q) begin
            byte_lane_enables_n <= (size16_s && be_n_q[1:0] != 2'b11 && be_n_q[3:2] != 2'b11)
                                   ? (be_n_q | `LBC_BE_MASK_HI) : be_n_q;
         end else if (state_q == ST_IO_T2 && local_ready_s && split_q && !phase_q) begin
            byte_lane_enables_n <= be_n_q | `LBC_BE_MASK_LO;
         end else if (state_q == ST_IO_END) begin
            lb_ctl_oe <= 1'b0;
            byte_lane_enables_n <= `LBC_BE_IDLE;
            burst_last_n <= 1'b1;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Data movement and I/O bus handshake.
   always_ff @(posedge clock) begin
      if (rst) begin
         lb_data_o <= '0;
         lb_data_oe <= 1'b0;
      end else if (state_q == ST_IDLE && io_start) begin
         lb_data_o <= (io_be_n[0] && !io_be_n[1] && !io_be_n[2])
                      ? {8'h00, io_wdata, 8'h00} : {io_wdata, io_wdata};
         lb_data_oe <= io_wr;
      end else if (state_q == ST_IO_END) begin
         lb_data_oe <= 1'b0;
      end
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         rd_q <= '0;
         io_rdata <= '0;
         io_wait <= 1'b0;
         io_done <= 1'b0;
         io_local <= 1'b0;
      end else begin
         io_done <= (state_q == ST_IO_END);
         if (state_q == ST_IDLE && io_start) begin
            io_wait <= 1'b1;
            rd_q <= '0;
         end else if (state_q == ST_IO_T2 && local_ready_s && !wr_q) begin
            rd_q <= rd_merge;
         end else if (state_q == ST_IO_END) begin
            io_wait <= 1'b0;
            io_local <= claimed_q;
            if (be_n_q[1:0] == 2'b11) begin
               io_rdata <= rd_q[31:16];
            end else if (be_n_q[0] && !be_n_q[1] && !be_n_q[2]) begin
               io_rdata <= rd_q[23:8];
            end else begin
               io_rdata <= rd_q[15:0];
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Checks.
   a_decode_wait: assert property (@(posedge clock) disable iff (rst)
      (state_q == ST_IDLE && !cpu_ads_n && !io_start)
      |=> (state_q == ST_DECODE) [*3] ##1 (state_q != ST_DECODE))
      else $error("Claim sampled without the full decode interval.");
   a_claim_release: assert property (@(posedge clock) disable iff (rst)
      (sample && !is_io_q && claim_s && !bypass_q) |=> !board_rdy_oe && !board_data_oe)
      else $error("Board drivers not released on a claimed cycle.");
   a_cache_ignore: assert property (@(posedge clock) disable iff (rst)
      (sample && bypass_q) |=> board_rdy_oe && !claimed_q)
      else $error("Claim honoured on a cache hit or board memory cycle.");
   a_io_control: assert property (@(posedge clock) disable iff (rst)
      (state_q == ST_IO_T1 || state_q == ST_IO_T2) |-> lb_ctl_oe && is_io_q)
      else $error("Local control not driven during an I/O bus cycle.");
   a_strobe_cause: assert property (@(posedge clock) disable iff (rst)
      $fell(address_strobe_n) |-> is_io_q && (claimed_q || ads_always)
         && state_q == ST_IO_T1)
      else $error("Address strobe without claim or strobe-always.");
   a_io_wait_hold: assert property (@(posedge clock) disable iff (rst)
      (state_q == ST_IO_T2 && !local_ready_s) |=> io_wait && state_q == ST_IO_T2)
      else $error("I/O bus wait dropped before local ready.");
   a_read_latch: assert property (@(posedge clock) disable iff (rst)
      (io_done && !io_start) |=> $stable(io_rdata))
      else $error("Latched read data changed before the next cycle.");
   a_burst_last_low: assert property (@(posedge clock) disable iff (rst)
      (!address_strobe_n || state_q == ST_IO_T2) |-> !burst_last_n)
      else $error("Burst last not low through the I/O bus cycle.");
   a_split_second: assert property (@(posedge clock) disable iff (rst)
      (state_q == ST_IO_T2 && local_ready_s && split_q && !phase_q)
      |=> state_q == ST_IO_T1 && !address_strobe_n
         && byte_lane_enables_n == (be_n_q | `LBC_BE_MASK_LO) && io_wait)
      else $error("Second half of a split not issued correctly.");
   a_ready_combine: assert property (@(posedge clock) disable iff (rst)
      (state_q == ST_CPU_WAIT && claimed_q && local_ready_s) |=> !ready_return_n ##1 ready_return_n)
      else $error("Ready return not a single pulse after local ready.");
endmodule // lbc_host_ctrl
`default_nettype wire

// File: lbc_target_model.sv
// Behavioural local bus target that claims, sizes and answers controller cycles.
`timescale 1ns/10ps
`default_nettype none
module lbc_target_model #(
   parameter logic [31:0] RD_DATA = 32'hD4C3B2A1
) (
   input wire logic clock,
   input wire logic rst,
   input wire logic [31:2] lb_addr,
   input wire logic lb_ctl_oe,
   input wire logic address_strobe_n,
   input wire logic burst_last_n,
   input wire logic cpu_ads_n,
   input wire logic cpu_claim,
   input wire logic wide16,
   input wire logic [3:0] wait_cycles,
   output logic local_device_claim_n,
   output logic local_ready_n,
   output logic burst_ready_n,
   output logic size16_request_n,
   output logic [31:0] lb_data_i
);
   logic match;
   logic busy_q;
   logic burst_last_hi_q;
   logic [3:0] cnt_q;
   logic [1:0] hold_q;
   // The claim is a plain decode of the address or the cpu_claim input, never latched.
   assign match = (lb_ctl_oe && lb_addr[31:28] == 4'hA) || cpu_claim;
   assign local_device_claim_n = !match;
   assign size16_request_n = !(match && wide16);
   // Read data is valid from the ready cycle for two more cycles, inverted otherwise.
   assign lb_data_i = (hold_q != 2'h0) ? RD_DATA : ~RD_DATA;
   always_ff @(posedge clock) begin
      local_ready_n <= 1'b1;
      burst_ready_n <= 1'b1;
      if (rst) begin
         busy_q <= 1'b0;
         hold_q <= 2'h0;
         cnt_q <= 4'h0;
      end else if (!busy_q && match && (!address_strobe_n || !cpu_ads_n)) begin
         busy_q <= 1'b1;
         cnt_q <= wait_cycles;
         burst_last_hi_q <= !address_strobe_n && burst_last_n;
      end else if (busy_q && cnt_q != 4'h0) begin
         cnt_q <= cnt_q - 4'h1;
      end else if (busy_q) begin
         busy_q <= 1'b0;
         hold_q <= 2'h3;
         // A cycle whose burst last was high at the first state ends with burst ready.
         if (burst_last_hi_q) begin
            burst_ready_n <= 1'b0;
         end else begin
            local_ready_n <= 1'b0;
         end
      end else if (hold_q != 2'h0) begin
         hold_q <= hold_q - 2'h1;
      end
   end
endmodule // lbc_target_model
`default_nettype wire

// File: local_bus_host_controller_tb.sv
// Self-checking bench for the local bus host controller.
`timescale 1ns/10ps
`default_nettype none
module local_bus_host_controller_tb;
   logic clock, rst, cpu_ads_n, cpu_wr, cpu_cache_hit, cpu_local_mem, board_ready_n;
   logic ads_always, io_start, io_mio, io_dc, io_wr, cpu_claim, wide16;
   logic [31:2] io_addr, lb_addr;
   logic [3:0] io_be_n, wait_cycles, byte_lane_enables_n;
   logic [15:0] io_wdata, io_rdata;
   logic local_device_claim_n, local_ready_n, burst_ready_n, size16_request_n;
   logic [31:0] lb_data_i, lb_data_o;
   logic ready_return_n, cpu_size16_n, board_rdy_oe, board_data_oe, io_wait, io_done;
   logic io_local, address_strobe_n, lb_mio, lb_dc, lb_wr, burst_last_n, lb_ctl_oe;
   logic lb_data_oe;
   int mismatches, n_tests, cycles;
   lbc_host_ctrl u_dut (.clock, .rst, .cpu_ads_n, .cpu_wr, .cpu_cache_hit, .cpu_local_mem,
      .board_ready_n, .ads_always, .io_start, .io_addr, .io_be_n, .io_mio, .io_dc, .io_wr,
      .io_wdata, .local_device_claim_n, .local_ready_n, .burst_ready_n, .size16_request_n,
      .lb_data_i, .ready_return_n, .cpu_size16_n, .board_rdy_oe, .board_data_oe, .io_wait,
      .io_done, .io_local, .io_rdata, .lb_addr, .byte_lane_enables_n, .address_strobe_n,
      .lb_mio, .lb_dc, .lb_wr, .burst_last_n, .lb_ctl_oe, .lb_data_o, .lb_data_oe);
   lbc_target_model u_target (.clock, .rst, .lb_addr, .lb_ctl_oe, .address_strobe_n,
      .burst_last_n, .cpu_ads_n, .cpu_claim, .wide16, .wait_cycles, .local_device_claim_n,
      .local_ready_n, .burst_ready_n, .size16_request_n, .lb_data_i);
   always #10 clock = ~clock;
   always @(posedge clock) begin
      cycles++;
      if (cycles == 5000) begin
         mismatches++;
         test_done();
      end
   end
   ////////////////////////////////////////////////////////////////////////////////
   task automatic check(input logic [35:0] seen, input logic [35:0] expected);
      n_tests++;
      if (seen !== expected) begin
         mismatches++;
         $display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, expected);
      end
   endtask
   task automatic test_done();
      $display("comparisons %0d mismatches %0d", n_tests, mismatches);
      if (mismatches == 0 && n_tests > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   // One processor cycle; the board's own ready answers when no target owns it.
   task automatic cpu_cycle(input logic claim, hit, mem, wr, wide);
      logic eff;
      int k;
      eff = claim && !hit && !mem;
      @(posedge clock);
      #2;
      cpu_claim = claim;
      wide16 = wide;
      wait_cycles = 4'h2;
      cpu_ads_n = 1'b0;
      cpu_wr = wr;
      cpu_cache_hit = hit;
      cpu_local_mem = mem;
      board_ready_n = eff;
      @(posedge clock);
      #2;
      cpu_ads_n = 1'b1;
      for (k = 0; k < 40 && ready_return_n !== 1'b0; k++) begin
         @(posedge clock);
         #1;
         if (k == 3) begin
            check(board_rdy_oe, !eff);
            check(board_data_oe, !eff && !wr);
            check(cpu_size16_n, !(claim && wide));
         end
      end
      check(ready_return_n, 1'b0);
      @(posedge clock);
      #1;
      check(ready_return_n, 1'b1);
      board_ready_n = 1'b1;
      cpu_claim = 1'b0;
      $display("cpu cycle test done");
   endtask
   // One I/O bus cycle; the target stands in the upper address range.
   task automatic io_cycle(input logic [31:2] addr, input logic [3:0] be, input logic wr,
      input logic wide, input logic [3:0] ws, input logic [15:0] exp_rd,
      input logic local_exp, input int n_strobe);
      int n;
      int k;
      logic [3:0] be_seen [2];
      logic [31:0] wexp;
      n = 0;
      wexp = (be == 4'h9) ? {8'h00, 16'h5AA5, 8'h00} : {16'h5AA5, 16'h5AA5};
      @(posedge clock);
      #2;
      wide16 = wide;
      wait_cycles = ws;
      io_start = 1'b1;
      io_addr = addr;
      io_be_n = be;
      io_wr = wr;
      @(posedge clock);
      #2;
      io_start = 1'b0;
      for (k = 0; k < 80 && io_done !== 1'b1; k++) begin
         @(posedge clock);
         #1;
         if (io_done !== 1'b1) begin
            check(io_wait, 1'b1);
            if (lb_ctl_oe === 1'b1) begin
               check(burst_last_n, 1'b0);
               check({lb_addr, lb_mio, lb_dc, lb_wr}, {addr, 1'b1, 1'b0, wr});
            end
            if (address_strobe_n === 1'b0) begin
               if (n < 2) be_seen[n] = byte_lane_enables_n;
               n++;
               check(lb_data_oe, wr);
               if (wr) check(lb_data_o, wexp);
            end
         end
      end
      check(io_done, 1'b1);
      check(n, n_strobe);
      if (n_strobe == 2) check({be_seen[0], be_seen[1]}, {be | 4'hC, be | 4'h3});
      if (n_strobe == 1) check(be_seen[0], be);
      check(io_local, local_exp);
      @(posedge clock);
      #1;
      check(io_done, 1'b0);
      if (local_exp && !wr) begin
         repeat (5) @(posedge clock);
         #1;
         check(io_rdata, exp_rd);
      end
      $display("io cycle test done");
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      {clock, cpu_wr, cpu_cache_hit, cpu_local_mem, ads_always, io_start, io_wr} = '0;
      {rst, cpu_ads_n, board_ready_n, io_mio} = 4'hF;
      {io_dc, cpu_claim, wide16} = '0;
      io_addr = '0;
      io_be_n = 4'hF;
      io_wdata = 16'h5AA5;
      wait_cycles = 4'h1;
      {mismatches, n_tests, cycles} = '0;
      repeat (4) @(posedge clock);
      #2;
      rst = 1'b0;
      cpu_cycle(1'b1, 1'b0, 1'b0, 1'b0, 1'b0);
      cpu_cycle(1'b1, 1'b0, 1'b0, 1'b1, 1'b1);
      cpu_cycle(1'b1, 1'b1, 1'b0, 1'b0, 1'b0);
      cpu_cycle(1'b1, 1'b0, 1'b1, 1'b0, 1'b0);
      cpu_cycle(1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
      io_cycle(30'h2800_0040, 4'hC, 1'b0, 1'b0, 4'h1, 16'hB2A1, 1'b1, 1);
      io_cycle(30'h2800_0040, 4'h3, 1'b0, 1'b0, 4'h6, 16'hD4C3, 1'b1, 1);
      io_cycle(30'h2800_0044, 4'h9, 1'b0, 1'b1, 4'h1, 16'hC3B2, 1'b1, 2);
      io_cycle(30'h2800_0048, 4'h0, 1'b1, 1'b1, 4'h2, 16'h0000, 1'b1, 2);
      io_cycle(30'h2800_0048, 4'h9, 1'b1, 1'b0, 4'h0, 16'h0000, 1'b1, 1);
      io_cycle(30'h0000_0400, 4'hC, 1'b0, 1'b0, 4'h1, 16'h0000, 1'b0, 0);
      ads_always = 1'b1;
      io_cycle(30'h0000_0400, 4'hC, 1'b0, 1'b0, 4'h1, 16'h0000, 1'b0, 1);
      io_cycle(30'h2800_0040, 4'h0, 1'b0, 1'b1, 4'h0, 16'hB2A1, 1'b1, 2);
      test_done();
   end
endmodule // local_bus_host_controller_tb
`default_nettype wire
